// ===== pkg/chg_pkg.sv
// constants, carriers and helpers for the charger limit/status registers
package chg_pkg;

  localparam int CUR_W = 3;
  localparam int FLT_W = 6;
  localparam int CAP_W = 4;

  localparam logic [7:0] ADDR_PARAM_RST = 8'h04;
  localparam logic [7:0] ADDR_WEAK      = 8'h05;
  localparam logic [7:0] ADDR_SAFETY    = 8'h06;
  localparam logic [7:0] ADDR_MON       = 8'h10;

  localparam int PARAM_RST_BIT = 7;
  localparam int WS_OFF_BIT    = 6;
  localparam int WS_FIXED_BIT  = 5;
  localparam int WS_FLAG_BIT   = 4;
  localparam int WS_VOLT_LSB   = 0;
  localparam int SAFE_I_LSB    = 4;
  localparam int SAFE_V_LSB    = 0;

  localparam logic             WS_OFF_RST   = 1'b0;
  localparam logic             WS_FIXED_RST = 1'b1;
  localparam logic [2:0]       WS_VOLT_RST  = 3'h4;
  localparam logic [7:0]       SAFETY_RST   = 8'h40;
  localparam logic [1:0]       FLOAT_FILL   = 2'h3;
  localparam logic [7:0]       BYTE_ZERO    = 8'h00;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } chg_req_t;

  // bit order matches the monitor register, bit 7 first
  typedef struct packed {
    logic term_cmp;
    logic batt_cmp;
    logic trickle_on;
    logic thermal_limit;
    logic charge_loop_n;
    logic input_loop_n;
    logic supply_ok;
    logic const_volt;
  } chg_mon_t;

  typedef struct packed {
    chg_mon_t mon;
    logic     weak_source;
    logic     thermal_shutdown;
  } chg_ana_t;

  function automatic logic req_write(chg_req_t r, logic [7:0] a);
    return r.valid && r.write && (r.addr == a);
  endfunction

  function automatic logic req_read(chg_req_t r, logic [7:0] a);
    return r.valid && !r.write && (r.addr == a);
  endfunction

  // ceiling code widened to the float-voltage code space
  function automatic logic [FLT_W-1:0] float_cap(logic [CAP_W-1:0] c);
    return {c, FLOAT_FILL};
  endfunction

endpackage

// ===== hdl/chg_sync.sv
// two-flop synchroniser for a vector of asynchronous status levels
`timescale 1ns/1ps
module chg_sync
  import chg_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk_sys_in,
  input  wire logic         srst_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// ===== hdl/chg_clamp.sv
// registered clamp of a programmed code against a ceiling
`timescale 1ns/1ps
module chg_clamp
  import chg_pkg::*;
#(
  parameter int W = 3
) (
  input  wire logic         clk_sys_in,
  input  wire logic         srst_in,
  input  wire logic [W-1:0] value_in,
  input  wire logic [W-1:0] ceiling_in,
  output logic      [W-1:0] used_out,
  output logic              clamped_out
);

  logic [W-1:0] used_q;
  logic         clamped_q;
  wire          over = value_in > ceiling_in;
  wire [W-1:0]  used_d = over ? ceiling_in : value_in;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      used_q    <= '0;
      clamped_q <= 1'b0;
    end else begin
      used_q    <= used_d;
      clamped_q <= over;
    end
  end

  assign used_out    = used_q;
  assign clamped_out = clamped_q;

  clamp_bound_a: assert property (
    @(posedge clk_sys_in) disable iff (srst_in)
    1'b1 |=> (used_q <= $past(ceiling_in)) &&
             (used_q == (($past(value_in) > $past(ceiling_in))
                         ? $past(ceiling_in) : $past(value_in))))
    else $error("clamped code exceeds or mismatches ceiling");

endmodule

// ===== hdl/chg_regs_top.sv
// weak-source, safety-limit and loop-monitor registers of the charger
`timescale 1ns/1ps
// Contract
// - weak-source bit 6 writable; 1 turns the auxiliary 1.8V regulator off.
// - bit 5 set forces current sense to 22.1mV; clear follows current setting.
// - bit 4 read-only, 1 while a weak input source is being regulated.
// - bits 2:0 writable, choose input regulation voltage under weak source.
// - safety bit 7 always reads 0.
// - safety bits 6:4 cap the charge current setting used by control.
// - safety bits 3:0 cap the float voltage used by control.
// - safety register resets to 0x40.
// - registers decode at 0x05, 0x06 and 0x10.
// - monitor bit 7 shows sensed current above termination threshold.
// - monitor bit 6 shows the battery voltage comparator output.
// - monitor bit 5 reads 1 while the 30mA linear charger runs.
// - thermal limit without shutdown limits charge current to 22.1mV sense.
// - monitor bits 3 and 2 read 0 while their current loop controls.
// - monitor bit 1 reads 1 once the input supply is validated.
// - monitor bit 0 reads 1 when float-voltage loop alone controls.
// - writing 1 to parameter reset restores defaults, safety register kept.
module chg_regs_top
  import chg_pkg::*;
(
  input  wire logic             clk_sys_in,
  input  wire logic             srst_in,
  input  wire chg_req_t         req_in,
  input  wire chg_ana_t         ana_in,
  input  wire logic [CUR_W-1:0] charge_current_setting_in,
  input  wire logic [FLT_W-1:0] float_voltage_in,
  output logic      [7:0]       rd_data_out,
  output logic                  rd_valid_out,
  output logic                  regulator_off_out,
  output logic                  fixed_low_current_out,
  output logic      [2:0]       weak_source_volt_out,
  output logic      [CUR_W-1:0] current_cmd_out,
  output logic      [FLT_W-1:0] float_cmd_out,
  output logic                  current_capped_out,
  output logic                  float_capped_out,
  output logic                  sense_low_out
);

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (srst_in);

  // analogue levels come from another domain
  chg_ana_t ana_s;

  chg_sync #(
    .W ($bits(chg_ana_t))
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .async_in   (ana_in),
    .sync_out   (ana_s)
  );

  // weak-source register state
  logic       ws_off_q;
  logic       ws_off_d;
  logic       ws_fixed_q;
  logic       ws_fixed_d;
  logic [2:0] ws_volt_q;
  logic [2:0] ws_volt_d;

  // safety register state; bit 7 is not stored
  logic [CUR_W-1:0] safe_i_q;
  logic [CUR_W-1:0] safe_i_d;
  logic [CAP_W-1:0] safe_v_q;
  logic [CAP_W-1:0] safe_v_d;

  // read path
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic       rd_valid_q;
  logic       sense_low_q;

  // request decode
  wire wr_weak   = req_write(req_in, ADDR_WEAK);
  wire wr_safety = req_write(req_in, ADDR_SAFETY);
  wire rd_weak   = req_read(req_in, ADDR_WEAK);
  wire rd_safety = req_read(req_in, ADDR_SAFETY);
  wire rd_mon    = req_read(req_in, ADDR_MON);
  wire rd_any    = req_in.valid && !req_in.write;
  wire param_rst = req_write(req_in, ADDR_PARAM_RST) &&
                   req_in.wdata[PARAM_RST_BIT];

  // next state of the weak-source fields; only writable bits taken
  assign ws_off_d   = param_rst ? WS_OFF_RST :
                      wr_weak   ? req_in.wdata[WS_OFF_BIT] :
                                  ws_off_q;
  assign ws_fixed_d = param_rst ? WS_FIXED_RST :
                      wr_weak   ? req_in.wdata[WS_FIXED_BIT] :
                                  ws_fixed_q;
  assign ws_volt_d  = param_rst ? WS_VOLT_RST :
                      wr_weak   ? req_in.wdata[WS_VOLT_LSB +: 3] :
                                  ws_volt_q;

  // safety fields ignore the parameter reset
  assign safe_i_d = wr_safety ? req_in.wdata[SAFE_I_LSB +: CUR_W]
                              : safe_i_q;
  assign safe_v_d = wr_safety ? req_in.wdata[SAFE_V_LSB +: CAP_W]
                              : safe_v_q;

  // read images; flag and reserved bits are never stored
  wire [7:0] weak_img;
  wire [7:0] safety_img;
  wire [7:0] mon_img;

  assign weak_img = {1'b0, ws_off_q, ws_fixed_q, ana_s.weak_source,
                     1'b0, ws_volt_q};
  assign safety_img = {1'b0, safe_i_q, safe_v_q};
  assign mon_img = ana_s.mon;

  // unmapped reads answer zero
  assign rd_data_d = rd_weak   ? weak_img   :
                     rd_safety ? safety_img :
                     rd_mon    ? mon_img    :
                                 BYTE_ZERO;

  // 22.1mV sense either by request or by thermal regulation
  wire sense_low_d = ws_fixed_q ||
                     (ana_s.mon.thermal_limit &&
                      !ana_s.thermal_shutdown);

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ws_off_q   <= WS_OFF_RST;
      ws_fixed_q <= WS_FIXED_RST;
      ws_volt_q  <= WS_VOLT_RST;
    end else begin
      ws_off_q   <= ws_off_d;
      ws_fixed_q <= ws_fixed_d;
      ws_volt_q  <= ws_volt_d;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      safe_i_q <= SAFETY_RST[SAFE_I_LSB +: CUR_W];
      safe_v_q <= SAFETY_RST[SAFE_V_LSB +: CAP_W];
    end else begin
      safe_i_q <= safe_i_d;
      safe_v_q <= safe_v_d;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rd_data_q   <= BYTE_ZERO;
      rd_valid_q  <= 1'b0;
      sense_low_q <= 1'b0;
    end else begin
      rd_data_q   <= rd_any ? rd_data_d : rd_data_q;
      rd_valid_q  <= rd_any;
      sense_low_q <= sense_low_d;
    end
  end

  // programmed codes held at or below their ceilings
  chg_clamp #(
    .W (CUR_W)
  ) u_cur_clamp (
    .clk_sys_in  (clk_sys_in),
    .srst_in     (srst_in),
    .value_in    (charge_current_setting_in),
    .ceiling_in  (safe_i_q),
    .used_out    (current_cmd_out),
    .clamped_out (current_capped_out)
  );

  chg_clamp #(
    .W (FLT_W)
  ) u_flt_clamp (
    .clk_sys_in  (clk_sys_in),
    .srst_in     (srst_in),
    .value_in    (float_voltage_in),
    .ceiling_in  (float_cap(safe_v_q)),
    .used_out    (float_cmd_out),
    .clamped_out (float_capped_out)
  );

  assign rd_data_out           = rd_data_q;
  assign rd_valid_out          = rd_valid_q;
  assign regulator_off_out     = ws_off_q;
  assign fixed_low_current_out = ws_fixed_q;
  assign weak_source_volt_out  = ws_volt_q;
  assign sense_low_out         = sense_low_q;

  // checks

  reg_off_a: assert property (
    wr_weak |=> regulator_off_out == $past(req_in.wdata[WS_OFF_BIT]))
    else $error("regulator off bit not taken from write");

  sense_low_a: assert property (
    (ws_fixed_q || (ana_s.mon.thermal_limit && !ana_s.thermal_shutdown))
      |=> sense_low_out)
    else $error("low sense not forced");

  sense_free_a: assert property (
    (!ws_fixed_q && (!ana_s.mon.thermal_limit || ana_s.thermal_shutdown))
      |=> !sense_low_out)
    else $error("low sense forced without cause");

  weak_flag_a: assert property (
    rd_weak |=> rd_valid_out &&
                rd_data_out[WS_FLAG_BIT] == $past(ana_s.weak_source))
    else $error("weak source flag misreported");

  volt_write_a: assert property (
    wr_weak ##1 !(wr_weak || param_rst) [*2]
      |-> weak_source_volt_out == $past(req_in.wdata[2:0], 2))
    else $error("regulation voltage field not held");

  safety_rsvd_a: assert property (
    rd_safety |=> rd_valid_out && !rd_data_out[7])
    else $error("safety reserved bit read as one");

  safety_reset_a: assert property (
    @(posedge clk_sys_in) disable iff (1'b0)
    srst_in |=> {1'b0, safe_i_q, safe_v_q} == SAFETY_RST)
    else $error("safety register reset value wrong");

  mon_read_a: assert property (
    rd_mon |=> rd_valid_out && rd_data_out == $past(ana_s.mon))
    else $error("monitor read does not show live status");

  mon_live_a: assert property (
    rd_mon |=> rd_data_out[1:0] ==
               $past({ana_s.mon.supply_ok, ana_s.mon.const_volt}))
    else $error("supply or constant-voltage flag wrong");

  unmapped_a: assert property (
    (rd_any && !rd_weak && !rd_safety && !rd_mon)
      |=> rd_valid_out && rd_data_out == BYTE_ZERO)
    else $error("unmapped read not answered with zero");

  param_rst_a: assert property (
    param_rst |=> ws_volt_q == WS_VOLT_RST && ws_fixed_q == WS_FIXED_RST &&
                  ws_off_q == WS_OFF_RST && $stable(safe_i_q) &&
                  $stable(safe_v_q))
    else $error("parameter reset wrong or touched safety");

  ro_write_a: assert property (
    req_write(req_in, ADDR_MON) |=> $stable({ws_off_q, ws_fixed_q,
                                            ws_volt_q, safe_i_q, safe_v_q}))
    else $error("write to monitor changed a register");

  weak_rsvd_a: assert property (
    rd_weak |=> !rd_data_out[7] && !rd_data_out[3])
    else $error("weak-source reserved bits read as one");

  fixed_write_a: assert property (
    wr_weak |=> fixed_low_current_out == $past(req_in.wdata[WS_FIXED_BIT]))
    else $error("fixed low current bit not taken from write");

  weak_hold_a: assert property (
    !(wr_weak || param_rst) |=> $stable({ws_off_q, ws_fixed_q, ws_volt_q}))
    else $error("weak-source field changed without a write");

  safety_write_a: assert property (
    wr_safety |=> {safe_i_q, safe_v_q} == $past(req_in.wdata[6:0]))
    else $error("safety fields not taken from write");

  safety_hold_a: assert property (
    !wr_safety |=> $stable({safe_i_q, safe_v_q}))
    else $error("safety field changed without a write");

  read_pulse_a: assert property (
    !rd_any |=> !rd_valid_out && $stable(rd_data_out))
    else $error("read answer without a read request");

  cur_ceiling_a: assert property (
    1'b1 |=> (current_cmd_out <= $past(safe_i_q)) &&
             (current_capped_out == ($past(charge_current_setting_in) >
                                     $past(safe_i_q))))
    else $error("current command above its ceiling");

  flt_ceiling_a: assert property (
    1'b1 |=> (float_cmd_out <= $past(float_cap(safe_v_q))) &&
             (float_capped_out == ($past(float_voltage_in) >
                                   $past(float_cap(safe_v_q)))))
    else $error("float command above its ceiling");

  param_zero_a: assert property (
    (req_write(req_in, ADDR_PARAM_RST) && !req_in.wdata[PARAM_RST_BIT])
      |=> $stable({ws_off_q, ws_fixed_q, ws_volt_q}))
    else $error("parameter reset taken from a zero write");

  weak_read_a: assert property (
    rd_weak |=> {rd_data_out[6:5], rd_data_out[2:0]} ==
                $past({ws_off_q, ws_fixed_q, ws_volt_q}))
    else $error("weak-source read image wrong");

  safety_read_a: assert property (
    rd_safety |=> rd_data_out[6:0] == $past({safe_i_q, safe_v_q}))
    else $error("safety read image wrong");

  unmapped_write_a: assert property (
    (req_in.valid && req_in.write && !wr_weak && !wr_safety && !param_rst)
      |=> $stable({ws_off_q, ws_fixed_q, ws_volt_q, safe_i_q, safe_v_q}))
    else $error("write to an unmapped address changed a register");

endmodule

// ===== tb/chg_host_model.sv
// host-side model issuing byte requests on the register port
`timescale 1ns/1ps
module chg_host_model
  import chg_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic [7:0] rd_data_in,
  input  wire logic       rd_valid_in,
  output chg_req_t        req_out
);
  initial req_out = '0;

  // idle lines flip so a stale request never looks held
  task automatic release_bus();
    req_out.valid = 1'b0;
    req_out.write = ~req_out.write;
    req_out.addr  = ~req_out.addr;
    req_out.wdata = ~req_out.wdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    req_out = '{1'b1, 1'b1, a, d};
    @(negedge clk_sys_in);
    release_bus();
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    ok = 1'b0;
    d  = 8'h00;
    @(negedge clk_sys_in);
    req_out = '{1'b1, 1'b0, a, 8'h00};
    @(negedge clk_sys_in);
    release_bus();
    for (int i = 0; i < 4 && !ok; i++) begin
      if (rd_valid_in === 1'b1) begin
        ok = 1'b1;
        d  = rd_data_in;
      end else begin
        @(negedge clk_sys_in);
      end
    end
  endtask
endmodule

// ===== tb/chg_regs_top_tb.sv
// self-checking bench for the charger limit/status registers
`timescale 1ns/1ps
module chg_regs_top_tb;
  import chg_pkg::*;
  typedef struct { logic [7:0] wa, wd, ra, ex; } chg_row_t;
  logic             clk_sys_in;
  logic             srst_in;
  chg_req_t         req;
  chg_ana_t         ana;
  logic [CUR_W-1:0] cur_set, cur_cmd;
  logic [FLT_W-1:0] flt_set, flt_cmd;
  logic [7:0]       rd_data, got;
  logic [2:0]       ws_volt;
  logic             rd_valid, reg_off, fixed_low, cur_cap, flt_cap;
  logic             sense_low, ok;
  int               bad_count = 0;
  int               tests_run = 0;
  chg_row_t rows[6] = '{
    '{8'h05, 8'hFF, 8'h05, 8'h67}, '{8'h05, 8'h00, 8'h05, 8'h00},
    '{8'h06, 8'hFF, 8'h06, 8'h7F}, '{8'h06, 8'h35, 8'h06, 8'h35},
    '{8'h10, 8'hFF, 8'h10, 8'h00}, '{8'h20, 8'h55, 8'h20, 8'h00}};
  logic [7:0] mon_vals[2] = '{8'hA5, 8'h5A};

  chg_regs_top dut (
    .clk_sys_in                (clk_sys_in),
    .srst_in                   (srst_in),
    .req_in                    (req),
    .ana_in                    (ana),
    .charge_current_setting_in (cur_set),
    .float_voltage_in          (flt_set),
    .rd_data_out               (rd_data),
    .rd_valid_out              (rd_valid),
    .regulator_off_out         (reg_off),
    .fixed_low_current_out     (fixed_low),
    .weak_source_volt_out      (ws_volt),
    .current_cmd_out           (cur_cmd),
    .float_cmd_out             (flt_cmd),
    .current_capped_out        (cur_cap),
    .float_capped_out          (flt_cap),
    .sense_low_out             (sense_low)
  );

  chg_host_model host (
    .clk_sys_in  (clk_sys_in),
    .rd_data_in  (rd_data),
    .rd_valid_in (rd_valid),
    .req_out     (req)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(string n, logic [7:0] seen, logic [7:0] ex);
    tests_run++;
    if (seen !== ex) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, ex, seen);
    end
  endtask

  task automatic idle(int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  // read with bounded wait; a missing answer ends the run
  task automatic rchk(string n, logic [7:0] a, logic [7:0] ex);
    host.rd(a, got, ok);
    if (!ok) begin
      bad_count++;
      $display("[ERR] %s expected answer seen none", n);
      summarize();
    end else begin
      check(n, got, ex);
    end
  endtask

  task automatic clamp(logic [2:0] c, logic [5:0] f, logic [2:0] ec,
                       logic [5:0] ef, logic cc, logic fc);
    cur_set = c;
    flt_set = f;
    idle(3);
    check("current_cmd", 8'(cur_cmd), 8'(ec));
    check("current_capped", 8'(cur_cap), 8'(cc));
    check("float_cmd", 8'(flt_cmd), 8'(ef));
    check("float_capped", 8'(flt_cap), 8'(fc));
  endtask

  initial begin
    srst_in = 1'b1;
    ana     = '0;
    cur_set = '0;
    flt_set = '0;
    idle(5);
    srst_in = 1'b0;
    rchk("safety_reset", 8'h06, 8'h40);
    rchk("weak_reset", 8'h05, 8'h24);
    foreach (rows[i]) begin
      host.wr(rows[i].wa, rows[i].wd);
      rchk("row_read", rows[i].ra, rows[i].ex);
    end
    host.wr(8'h05, 8'h47);
    idle(1);
    check("regulator_off", 8'(reg_off), 8'h01);
    check("fixed_low", 8'(fixed_low), 8'h00);
    check("weak_volt", 8'(ws_volt), 8'h07);
    clamp(3'h7, 6'h3F, 3'h3, 6'h17, 1'b1, 1'b1);
    clamp(3'h2, 6'h10, 3'h2, 6'h10, 1'b0, 1'b0);
    clamp(3'h3, 6'h17, 3'h3, 6'h17, 1'b0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      ana.mon.thermal_limit = k[0];
      ana.thermal_shutdown  = k[1];
      idle(5);
      check("sense_thermal", 8'(sense_low), 8'(k == 1));
    end
    host.wr(8'h05, 8'h20);
    idle(4);
    check("sense_fixed", 8'(sense_low), 8'h01);
    ana.weak_source = 1'b1;
    idle(4);
    rchk("weak_flag", 8'h05, 8'h30);
    ana.weak_source = 1'b0;
    host.wr(8'h05, 8'hB8);
    rchk("weak_flag_ro", 8'h05, 8'h20);
    ana.weak_source = 1'b1;
    foreach (mon_vals[i]) begin
      ana.mon = mon_vals[i];
      idle(4);
      rchk("monitor", 8'h10, mon_vals[i]);
    end
    host.wr(8'h05, 8'h47);
    host.wr(8'h04, 8'h00);
    rchk("param_zero", 8'h05, 8'h57);
    host.wr(8'h04, 8'h80);
    rchk("param_weak", 8'h05, 8'h34);
    rchk("param_safety", 8'h06, 8'h35);
    srst_in = 1'b1;
    idle(2);
    srst_in = 1'b0;
    rchk("safety_rereset", 8'h06, 8'h40);
    summarize();
  end
endmodule
